// ===== vdc_ctrl.sv
// controller that sequences dual-port video dram cycles on its strobe pins
//
// Contract
// - row then column address, 18 bits
// - transfer enable high access, low transfer
// - read: write enable high through column
// - drop output enable after row falls
// - mask enable low at row selects masked
// - mask on data pins at row fall
// - masked block: low selects, high at column
// - transfer picks direction and split
// - column strobe falls in every transfer
// - real time copy on enable rise
// - full transfer precedes split transfers
`timescale 1ns/1ns
module vdc_ctrl
    import vdc_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // user command port
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire vdc_pkg::vdc_cmd_s cmd,
    // user read answers and transfer status
    output logic rd_valid,
    output logic [vdc_pkg::DATA_W-1:0] rd_data,
    output logic split_refused,
    output logic half_status,
    // device strobes and address
    output vdc_pkg::vdc_strobe_s strobe,
    output logic [vdc_pkg::ADDR_W-1:0] addr_pins,
    // device random data pins
    input wire logic [vdc_pkg::DATA_W-1:0] dq_in,
    output logic [vdc_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe,
    // device serial status pin
    input wire logic half_status_pin
);
    import vdc_pkg::*;

    // ****************************************************************
    // command queue
    // ****************************************************************
    logic q_valid;
    logic q_ready;
    logic [CMD_W-1:0] q_bits;
    vdc_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data(cmd),
        .out_valid(q_valid),
        .out_ready(q_ready),
        .out_data(q_bits)
    );

    // ****************************************************************
    // pin synchroniser and state
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE, ST_ROW, ST_COL, ST_LATE, ST_DATA, ST_END, ST_PRE
    } vdc_state_e;

    vdc_state_e state_reg;
    vdc_cmd_s cur_reg;
    vdc_strobe_s strobe_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] dq_out_reg;
    logic dq_oe_reg;
    logic rd_valid_reg;
    logic [DATA_W-1:0] rd_data_reg;
    logic full_done_reg;
    logic refused_reg;
    logic [DATA_W-1:0] dq_s1_reg;
    logic [DATA_W-1:0] dq_s2_reg;
    logic hs_s1_reg;
    logic hs_s2_reg;

    vdc_cmd_s q_cmd;
    assign q_cmd = vdc_cmd_s'(q_bits);

    // classify the current cycle once for the decode below, except idle which decodes q_cmd itself
    wire is_xfer = (cur_reg.op == VDC_OP_RT) || (cur_reg.op == VDC_OP_SRT);
    wire is_masked = (cur_reg.op == VDC_OP_MWRITE) || (cur_reg.op == VDC_OP_MBWRITE);
    wire is_block = (cur_reg.op == VDC_OP_BWRITE) || (cur_reg.op == VDC_OP_MBWRITE);
    wire is_read = (cur_reg.op == VDC_OP_READ);
    wire dsf_col = is_block || (cur_reg.op == VDC_OP_LCR);
    wire dsf_row = (cur_reg.op == VDC_OP_SRT) || (cur_reg.op == VDC_OP_LCR);
    wire [ADDR_W-1:0] row_a = cur_reg.addr[WORD_ADDR_W-1:ADDR_W];
    wire [ADDR_W-1:0] col_a = is_block ? {cur_reg.addr[ADDR_W-1:2], 2'b00}
                                       : cur_reg.addr[ADDR_W-1:0];
    // block writes put the four column enables on the low data pins
    wire [DATA_W-1:0] col_data = is_block ? {4'h0, cur_reg.data[3:0]}
                                          : cur_reg.data;
    wire split_bad = (q_cmd.op == VDC_OP_SRT) && !full_done_reg;

    assign q_ready = (state_reg == ST_IDLE);

    // two stage sync for pins from the device, first stage read only by second
    always_ff @(posedge clk) begin
        dq_s1_reg <= dq_in;
        dq_s2_reg <= dq_s1_reg;
        hs_s1_reg <= half_status_pin;
        hs_s2_reg <= hs_s1_reg;
    end

    // ****************************************************************
    // cycle sequencer, one step per clock
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            cur_reg <= '0;
            strobe_reg <= STROBE_IDLE;
            addr_reg <= '0;
            dq_out_reg <= '0;
            dq_oe_reg <= 1'b0;
            rd_valid_reg <= 1'b0;
            rd_data_reg <= '0;
            full_done_reg <= 1'b0;
            refused_reg <= 1'b0;
        end else begin
            rd_valid_reg <= 1'b0;
            refused_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    // split transfer without a prior full one would lose the half
                    if (q_valid && split_bad) begin
                        refused_reg <= 1'b1;
                    end else if (q_valid) begin
                        cur_reg <= q_cmd;
                        addr_reg <= q_cmd.addr[WORD_ADDR_W-1:ADDR_W];
                        strobe_reg.transfer_or_output_enable_n_n <= !((q_cmd.op == VDC_OP_RT)
                            || (q_cmd.op == VDC_OP_SRT));
                        strobe_reg.mask_or_write_enable_n_n <= !((q_cmd.op == VDC_OP_MWRITE)
                            || (q_cmd.op == VDC_OP_MBWRITE));
                        strobe_reg.special_function_select <= (q_cmd.op == VDC_OP_SRT)
                            || (q_cmd.op == VDC_OP_LCR);
                        dq_out_reg <= q_cmd.mask;
                        dq_oe_reg <= (q_cmd.op == VDC_OP_MWRITE)
                            || (q_cmd.op == VDC_OP_MBWRITE);
                        state_reg <= ST_ROW;
                    end
                end
                ST_ROW: begin
                    strobe_reg.ras_n <= 1'b0;
                    state_reg <= ST_COL;
                end
                ST_COL: begin
                    // setup column address, data and select for the column edge
                    addr_reg <= col_a;
                    strobe_reg.special_function_select <= dsf_col;
                    strobe_reg.transfer_or_output_enable_n_n <= is_xfer ? 1'b0 : 1'b1;
                    strobe_reg.mask_or_write_enable_n_n <= (is_read || is_xfer || cur_reg.late_write);
                    dq_out_reg <= col_data;
                    dq_oe_reg <= !is_read && !is_xfer;
                    state_reg <= ST_LATE;
                end
                ST_LATE: begin
                    strobe_reg.cas_n <= 1'b0;
                    if (is_read) begin
                        strobe_reg.transfer_or_output_enable_n_n <= 1'b0;
                    end else if (!is_xfer) begin
                        strobe_reg.mask_or_write_enable_n_n <= 1'b0;
                    end
                    state_reg <= ST_DATA;
                end
                ST_DATA: begin
                    // real time copy happens when transfer enable rises here
                    if (is_xfer) begin
                        strobe_reg.transfer_or_output_enable_n_n <= 1'b1;
                    end
                    state_reg <= ST_END;
                end
                ST_END: begin
                    if (cur_reg.op == VDC_OP_RT) begin
                        full_done_reg <= 1'b1;
                    end
                    strobe_reg <= STROBE_IDLE;
                    dq_oe_reg <= 1'b0;
                    state_reg <= ST_PRE;
                end
                ST_PRE: begin
                    // the sync lags two edges, so the word seen while column was low lands here
                    if (is_read) begin
                        rd_data_reg <= dq_s2_reg;
                        rd_valid_reg <= 1'b1;
                    end
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    assign strobe = strobe_reg;
    assign addr_pins = addr_reg;
    assign dq_out = dq_out_reg;
    assign dq_oe = dq_oe_reg;
    assign rd_valid = rd_valid_reg;
    assign rd_data = rd_data_reg;
    assign split_refused = refused_reg;
    assign half_status = hs_s2_reg;

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_row_fall;
        $fell(strobe.ras_n);
    endsequence

    sequence s_col_fall;
        $fell(strobe.cas_n);
    endsequence

    property p_row_before_col;
        @(posedge clk) disable iff (!rst_n) s_col_fall |-> !strobe.ras_n;
    endproperty
    a_row_before_col: assert property (p_row_before_col) else $error("column before row");

    property p_col_follows_row;
        @(posedge clk) disable iff (!rst_n) s_row_fall |-> ##2 s_col_fall;
    endproperty
    a_col_follows_row: assert property (p_col_follows_row) else $error("column late");

    property p_xfer_select;
        @(posedge clk) disable iff (!rst_n)
            s_row_fall |-> (strobe.transfer_or_output_enable_n_n == !is_xfer);
    endproperty
    a_xfer_select: assert property (p_xfer_select) else $error("bad transfer select");

    property p_mask_select;
        @(posedge clk) disable iff (!rst_n)
            s_row_fall |-> (strobe.mask_or_write_enable_n_n == !is_masked) && (dq_oe == is_masked);
    endproperty
    a_mask_select: assert property (p_mask_select) else $error("bad mask select");

    property p_read_oe;
        @(posedge clk) disable iff (!rst_n)
            (s_col_fall and is_read) |-> !strobe.transfer_or_output_enable_n_n && strobe.mask_or_write_enable_n_n && !dq_oe;
    endproperty
    a_read_oe: assert property (p_read_oe) else $error("read output enable wrong");

    property p_block_dsf;
        @(posedge clk) disable iff (!rst_n) s_col_fall |-> (strobe.special_function_select == dsf_col);
    endproperty
    a_block_dsf: assert property (p_block_dsf) else $error("bad column select");

    property p_block_addr;
        @(posedge clk) disable iff (!rst_n)
            (s_col_fall and is_block) |-> (addr_pins[1:0] == 2'b00);
    endproperty
    a_block_addr: assert property (p_block_addr) else $error("block low bits set");

    property p_rt_rise;
        @(posedge clk) disable iff (!rst_n)
            (s_col_fall and is_xfer) |-> ##1 strobe.transfer_or_output_enable_n_n && !strobe.cas_n;
    endproperty
    a_rt_rise: assert property (p_rt_rise) else $error("transfer enable not raised");

    property p_split_guard;
        @(posedge clk) disable iff (!rst_n)
            (s_row_fall and cur_reg.op == VDC_OP_SRT) |-> full_done_reg;
    endproperty
    a_split_guard: assert property (p_split_guard) else $error("split before full");
endmodule : vdc_ctrl

// ===== vdc_pkg.sv
// package of constants and carrier types for the video dram cycle driver
package vdc_pkg;
    // ****************************************************************
    // widths and timing
    // ****************************************************************
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int WORD_ADDR_W = 18;
    localparam int CLK_NS = 100;
    localparam int STEP_NS = 100;
    localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int HALF_POS = 256;
    localparam logic [3:0] CMD_FIFO_DEPTH = 4'h8;

    // ****************************************************************
    // cycle kinds and carriers
    // ****************************************************************
    typedef enum logic [2:0] {
        VDC_OP_READ, VDC_OP_WRITE, VDC_OP_MWRITE, VDC_OP_BWRITE,
        VDC_OP_MBWRITE, VDC_OP_LCR, VDC_OP_RT, VDC_OP_SRT
    } vdc_op_e;

    typedef struct packed {
        vdc_op_e op;
        logic [WORD_ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] mask;
        logic late_write;
    } vdc_cmd_s;

    localparam int CMD_W = $bits(vdc_cmd_s);

    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic transfer_or_output_enable_n_n;
        logic mask_or_write_enable_n_n;
        logic special_function_select;
    } vdc_strobe_s;

    localparam vdc_strobe_s STROBE_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
endpackage : vdc_pkg

// ===== vdc_fifo.sv
// small valid/ready fifo for queued cycle commands
`timescale 1ns/1ns
module vdc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0] count_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count_reg != (PW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_ptr_reg];

    // pointers wrap at depth so non power of two depths also work
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // storage has no reset, only written on push
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end
endmodule : vdc_fifo

// ===== vdc_dev_model.sv
// behavioural model of the video dram random-access port and transfer logic
`timescale 1ns/1ns
module vdc_dev_model
    import vdc_pkg::*;
(
    // strobes and address from the controller
    input wire vdc_pkg::vdc_strobe_s strobe,
    input wire logic [vdc_pkg::ADDR_W-1:0] addr_pins,
    // controller side of the data pins
    input wire logic [vdc_pkg::DATA_W-1:0] dq_out,
    input wire logic dq_oe,
    // resolved data pins and status
    output logic [vdc_pkg::DATA_W-1:0] dq_in,
    output logic half_status_pin,
    output logic srt_early
);
    // ****************
    // storage
    // ****************
    logic [DATA_W-1:0] mem [0:262143];
    logic [DATA_W-1:0] mask_reg = 8'hFF;
    logic [DATA_W-1:0] color_reg = 8'h00;
    logic [DATA_W-1:0] last_v = 8'h00;
    logic [ADDR_W-1:0] row, col, tap, sam_row;
    logic access, masked, row_dsf, col_dsf, dev_oe;
    logic rt_seen = 1'b0;
    vdc_strobe_s prev = STROBE_IDLE;
    initial begin
        half_status_pin = 1'b0;
        srt_early = 1'b0;
    end
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, n);
        return (o & ~mask_reg) | (n & mask_reg);
    endfunction : merge
    // ****************
    // data pins
    // ****************
    // read drivers only with row, column and output enable all low
    assign dev_oe = !strobe.ras_n && !strobe.cas_n && !strobe.transfer_or_output_enable_n_n && access
        && strobe.mask_or_write_enable_n_n;
    // no pull on these pins, so a released line shows the inverse of its last value
    assign dq_in = dq_oe ? dq_out : (dev_oe ? mem[{row, col}] : ~last_v);
    always @(dq_in) if (dq_oe || dev_oe) last_v = dq_in;
    // ****************
    // strobe edges
    // ****************
    // one process sees all strobes so simultaneous edges are judged together
    always @(strobe) begin
        if (prev.ras_n && !strobe.ras_n) begin
            row = addr_pins;
            access = strobe.transfer_or_output_enable_n_n;
            masked = !strobe.mask_or_write_enable_n_n;
            row_dsf = strobe.special_function_select;
            mask_reg = (access && masked) ? dq_in : 8'hFF;
            if (!access && row_dsf && !rt_seen) srt_early = 1'b1;
        end
        if (!strobe.ras_n && prev.cas_n && !strobe.cas_n) begin
            col = addr_pins;
            col_dsf = strobe.special_function_select;
            if (!access && !row_dsf) begin
                tap = addr_pins;
                half_status_pin = addr_pins[8];
                rt_seen = 1'b1;
            end
        end
        // data taken at the later of the column and write enable falls
        if (!strobe.ras_n && access && !strobe.cas_n && !strobe.mask_or_write_enable_n_n
            && (prev.cas_n || prev.mask_or_write_enable_n_n)) begin
            if (col_dsf && row_dsf) color_reg = dq_in;
            else if (col_dsf) begin
                for (int i = 0; i < 4; i++) begin
                    if (dq_in[i]) mem[{row, col[8:2], i[1:0]}] =
                        merge(mem[{row, col[8:2], i[1:0]}], color_reg);
                end
            end else mem[{row, col}] = merge(mem[{row, col}], dq_in);
        end
        if (!access && !strobe.ras_n && !strobe.cas_n && !prev.transfer_or_output_enable_n_n && strobe.transfer_or_output_enable_n_n)
            sam_row = row;
        if (!prev.ras_n && strobe.ras_n) mask_reg = 8'hFF;
        prev = strobe;
    end
endmodule : vdc_dev_model

// ===== vdc_ctrl_tb_top.sv
// self-checking bench for the video dram cycle controller
`timescale 1ns/1ns
module vdc_ctrl_tb_top;
    import vdc_pkg::*;
    // ****************
    // signals
    // ****************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    vdc_cmd_s cmd = '0;
    logic cmd_ready, rd_valid, split_refused, half_status, dq_oe, half_status_pin, srt_early;
    logic [DATA_W-1:0] rd_data, dq_in, dq_out;
    logic [ADDR_W-1:0] addr_pins;
    vdc_strobe_s strobe;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    int refusals = 0;
    logic full_seen = 1'b0;
    always #50 clk = ~clk;
    vdc_ctrl #(.FIFO_DEPTH(8)) i_vdc_ctrl (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd(cmd), .rd_valid(rd_valid), .rd_data(rd_data),
        .split_refused(split_refused), .half_status(half_status), .strobe(strobe),
        .addr_pins(addr_pins), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .half_status_pin(half_status_pin));
    vdc_dev_model i_vdc_dev_model (.strobe(strobe), .addr_pins(addr_pins), .dq_out(dq_out),
        .dq_oe(dq_oe), .dq_in(dq_in), .half_status_pin(half_status_pin), .srt_early(srt_early));
    // ****************
    // tasks
    // ****************
    task automatic chk_data(input logic [DATA_W-1:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected data at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk_data
    task automatic chk_flag(input logic got, exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected flag at %0t: got %b want %b", $time, got, exp);
        end
    endtask : chk_flag
    // offer one command and hold it until the fifo takes it
    task automatic send(input vdc_op_e op, input logic [WORD_ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, m, input logic late);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= '{op, a, d, m, late};
        @(posedge clk);
        while (cmd_ready !== 1'b1) @(posedge clk);
        cmd_valid <= 1'b0;
    endtask : send
    // queue a read, then wait a bounded time for its answer
    task automatic rd(input logic [WORD_ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        int n;
        send(VDC_OP_READ, a, 8'h00, 8'h00, 1'b0);
        n = 0;
        while (rd_valid !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk_flag(rd_valid, 1'b1);
        chk_data(rd_data, exp);
    endtask : rd
    task results;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    // ****************
    // monitors and timeout
    // ****************
    always @(posedge clk) begin
        if (split_refused === 1'b1) refusals++;
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            results();
        end
    end
    // ****************
    // tests
    // ****************
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk_flag(strobe === STROBE_IDLE, 1'b1);
        chk_flag(dq_oe, 1'b0);
        chk_flag(cmd_ready, 1'b1);
        // early and late writes read back
        send(VDC_OP_WRITE, 18'h12345, 8'h5A, 8'h00, 1'b0);
        send(VDC_OP_WRITE, 18'h00010, 8'hC3, 8'h00, 1'b1);
        rd(18'h12345, 8'h5A);
        rd(18'h00010, 8'hC3);
        // masked writes, late then early, over known words
        send(VDC_OP_WRITE, 18'h2A0F0, 8'hF0, 8'h00, 1'b0);
        send(VDC_OP_MWRITE, 18'h2A0F0, 8'h0F, 8'h3C, 1'b1);
        send(VDC_OP_WRITE, 18'h2A0F1, 8'hAA, 8'h00, 1'b0);
        send(VDC_OP_MWRITE, 18'h2A0F1, 8'h55, 8'h0F, 1'b0);
        rd(18'h2A0F0, 8'hCC);
        rd(18'h2A0F1, 8'hA5);
        // color load, block write on an unaligned column, then masked block write
        for (int i = 0; i < 4; i++) send(VDC_OP_WRITE, 18'(18'h06704 + i), 8'h00, 8'h00, 1'b0);
        send(VDC_OP_LCR, 18'h00000, 8'h96, 8'h00, 1'b0);
        send(VDC_OP_BWRITE, 18'h06705, 8'h05, 8'h00, 1'b0);
        for (int i = 0; i < 4; i++) rd(18'(18'h06704 + i), i[0] ? 8'h00 : 8'h96);
        send(VDC_OP_MBWRITE, 18'h06706, 8'h0A, 8'hF0, 1'b1);
        for (int i = 0; i < 4; i++) rd(18'(18'h06704 + i), i[0] ? 8'h90 : 8'h96);
        // split before any full transfer is dropped
        send(VDC_OP_SRT, 18'h00000, 8'h00, 8'h00, 1'b0);
        rd(18'h12345, 8'h5A);
        chk_flag(refusals == 1, 1'b1);
        // full transfers to upper and lower tap halves
        send(VDC_OP_RT, {9'h011, 9'h120}, 8'h00, 8'h00, 1'b0);
        rd(18'h12345, 8'h5A);
        chk_flag(half_status, 1'b1);
        chk_data(i_vdc_dev_model.sam_row[7:0], 8'h11);
        send(VDC_OP_RT, {9'h022, 9'h0FF}, 8'h00, 8'h00, 1'b0);
        rd(18'h00010, 8'hC3);
        chk_flag(half_status, 1'b0);
        chk_data(i_vdc_dev_model.sam_row[7:0], 8'h22);
        send(VDC_OP_SRT, {9'h022, 9'h010}, 8'h00, 8'h00, 1'b0);
        rd(18'h00010, 8'hC3);
        chk_flag(refusals == 1, 1'b1);
        chk_flag(srt_early, 1'b0);
        // back-to-back writes until the fifo refuses, then drain by reading back
        @(posedge clk);
        cmd_valid <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            cmd <= '{VDC_OP_WRITE, 18'(18'h30000 + i), 8'(i + 1), 8'h00, 1'b0};
            @(posedge clk);
            while (cmd_ready !== 1'b1) begin
                full_seen = 1'b1;
                @(posedge clk);
            end
        end
        cmd_valid <= 1'b0;
        chk_flag(full_seen, 1'b1);
        for (int i = 0; i < 20; i++) rd(18'(18'h30000 + i), 8'(i + 1));
        chk_flag(cmd_ready, 1'b1);
        results();
    end
endmodule : vdc_ctrl_tb_top
